/* src/protect_map_regs.svh */
/*
  Constants of the block protection map link: opcodes, map sizes, reset
  images, controller register offsets and link timing.
  Assumes inclusion by bare name; definitions only.
*/
`ifndef PROTECT_MAP_REGS_SVH
`define PROTECT_MAP_REGS_SVH

// ****************************************
// opcodes
// ****************************************
`define PM_OP_LATCH_SET   8'h06
`define PM_OP_LATCH_CLR   8'h04
`define PM_OP_MAP_WRITE   8'h42
`define PM_OP_MAP_FREEZE  8'h8D
`define PM_OP_MAP_READ    8'h72

// ****************************************
// map layout
// ****************************************
`define PM_BITS_16        7'h30
`define PM_BITS_32        7'h50
`define PM_NIB_16         5'h0C
`define PM_NIB_32         5'h14
`define PM_N64_16         7'h1E
`define PM_N64_32         7'h3E
`define PM_RST_16         80'h0000_0000_5555_FFFF_FFFF
`define PM_RST_32         80'h5555_FFFF_FFFF_FFFF_FFFF
`define PM_TOP_16         22'h1FFFFF
`define PM_TOP_32         22'h3FFFFF
`define PM_PAR_SPAN       22'h008000
`define PM_B32_END        22'h010000
`define PM_TOP_PAR_OFS    22'h007FFF
`define PM_TOP_32K_OFS    22'h00FFFF

// ****************************************
// controller registers
// ****************************************
`define PM_OFS_CMD        8'h00
`define PM_OFS_STATUS     8'h04
`define PM_OFS_TX0        8'h08
`define PM_OFS_TX1        8'h0C
`define PM_OFS_TX2        8'h10
`define PM_OFS_RX0        8'h14
`define PM_OFS_RX1        8'h18
`define PM_OFS_RX2        8'h1C
`define PM_RESP_OKAY      2'h0
`define PM_RESP_SLVERR    2'h2

// ****************************************
// timing
// ****************************************
`define PM_CLK_NS         100
`define PM_SCK_PERIOD_NS  2000
`define PM_SCK_HALF       (`PM_SCK_PERIOD_NS / 2 / `PM_CLK_NS)

`endif

/* src/protect_map_pkg.sv */
/*
  Types shared by both ends of the protection map link.
  Assumes protect_map_regs.svh for numeric constants.
*/
package protect_map_pkg;

  typedef enum logic [4:0] {
    D_IDLE = 5'h01,
    D_CMD  = 5'h02,
    D_DATA = 5'h04,
    D_READ = 5'h08,
    D_SKIP = 5'h10
  } dev_state_e;

  typedef enum logic [4:0] {
    H_IDLE = 5'h01,
    H_LOW  = 5'h02,
    H_HIGH = 5'h04,
    H_END  = 5'h08,
    H_GAP  = 5'h10
  } host_state_e;

  typedef enum logic [1:0] {
    OP_LATCH  = 2'h0,
    OP_WRITE  = 2'h1,
    OP_FREEZE = 2'h2,
    OP_READ   = 2'h3
  } host_op_e;

endpackage

/* src/protect_link_if.sv */
/*
  Four-bit serial link between the controller and the flash device.
  Assumes each end drives only its own half; the wire level is resolved here.
*/
`timescale 1ns/1ps
interface protect_link_if;
  logic       sck;
  logic       cs_n;
  logic [3:0] host_io;
  logic       host_oe;
  logic [3:0] dev_io;
  logic       dev_oe;
  logic [3:0] io;

  // pulled high when nobody drives
  assign io = host_oe ? host_io : (dev_oe ? dev_io : 4'hF);

  modport dev (input sck, input cs_n, input io, output dev_io, output dev_oe);
  modport host (output sck, output cs_n, output host_io, output host_oe, input io);
endinterface

/* src/protect_map_device.sv */
/*
  Device end: serial command decoder holding the block protection map,
  its write latch and freeze flag, and the address lock lookup.
  Assumes link pins asynchronous to aclk; aresetn stands for power-up.
*/
// Function
// - map write is 42H then data cycles
// - six data cycles small, ten large
// - cycle is two nibbles, upper first
// - small: bits 47-32 parameter read/write pairs
// - small: bits 31/30 lock 32K blocks
// - small: bits 29-0 lock 64K blocks
// - large: bits 79-64 parameter read/write pairs
// - large: bits 63/62 lock 32K blocks
// - large: bits 61-0 lock 64K blocks
// - reset: all write-locked, read-unlocked
// - after freeze, map changes refused
// - only power cycle clears freeze
// - freeze is opcode 8DH alone
// - write latch set must precede both
// - map read: nibbles out, then zeros
`timescale 1ns/1ps
`include "protect_map_regs.svh"
module protect_map_device
  import protect_map_pkg::*;
#(
  parameter bit LARGE = 1'b0
) (
  // clock and power-up reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // link
  protect_link_if.dev      link,
  // address check
  input  wire logic [21:0] chk_addr,
  output      logic        prog_blocked,
  output      logic        read_blocked,
  // state
  output      logic [79:0] map_out,
  output      logic        latch_out,
  output      logic        frozen_out
);

  localparam logic [6:0]  MAP_BITS = LARGE ? `PM_BITS_32 : `PM_BITS_16;
  localparam logic [4:0]  DATA_NIB = LARGE ? `PM_NIB_32 : `PM_NIB_16;
  localparam logic [6:0]  N64      = LARGE ? `PM_N64_32 : `PM_N64_16;
  localparam logic [79:0] MAP_RST  = LARGE ? `PM_RST_32 : `PM_RST_16;
  localparam logic [21:0] TOP      = LARGE ? `PM_TOP_32 : `PM_TOP_16;

  typedef struct packed {
    logic [2:0]  sck_s;
    logic [2:0]  cs_s;
    logic [11:0] io_s;
    logic        sck_st;
    logic        cs_st;
    logic [3:0]  io_st;
    dev_state_e  st;
    logic [4:0]  ncnt;
    logic [7:0]  op;
    logic [79:0] sh;
    logic [79:0] map;
    logic        wel;
    logic        frozen;
    logic [3:0]  dout;
    logic        doe;
    logic        wlk;
    logic        rlk;
  } dev_s;

  dev_s s_q;
  dev_s s_d;

  // ****************************************
  // address to lock bits
  // ****************************************
  function automatic logic [1:0] lock_of(input logic [21:0] a, input logic [79:0] m);
    logic [6:0] b;
    logic       par;
    b   = 7'h00;
    par = 1'b0;
    if (a > TOP) begin
      return 2'h0;
    end
    if (a < `PM_PAR_SPAN) begin
      b   = N64 + 7'h02 + {4'h0, a[14:13], 1'b0};
      par = 1'b1;
    end else if (a < `PM_B32_END) begin
      b = N64;
    end else if (a >= TOP - `PM_TOP_PAR_OFS) begin
      b   = N64 + 7'h0A + {4'h0, a[14:13], 1'b0};
      par = 1'b1;
    end else if (a >= TOP - `PM_TOP_32K_OFS) begin
      b = N64 + 7'h01;
    end else begin
      b = {1'b0, a[21:16]} - 7'h01;
    end
    return {par & m[b + 7'h01], m[b]};
  endfunction

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    logic       sck_n;
    logic       cs_n;
    logic [3:0] io_n;
    logic       rise;
    logic       fall;
    logic [7:0] opc;
    logic [1:0] lk;
    s_d   = s_q;
    opc   = 8'h00;
    lk    = lock_of(chk_addr, s_q.map);
    // three-stage filters, second and third must agree
    s_d.sck_s = {s_q.sck_s[1:0], link.sck};
    s_d.cs_s  = {s_q.cs_s[1:0], link.cs_n};
    s_d.io_s  = {s_q.io_s[7:0], link.io};
    sck_n = (s_q.sck_s[2] == s_q.sck_s[1]) ? s_q.sck_s[1] : s_q.sck_st;
    cs_n  = (s_q.cs_s[2] == s_q.cs_s[1]) ? s_q.cs_s[1] : s_q.cs_st;
    io_n  = (s_q.io_s[11:8] == s_q.io_s[7:4]) ? s_q.io_s[7:4] : s_q.io_st;
    s_d.sck_st = sck_n;
    s_d.cs_st  = cs_n;
    s_d.io_st  = io_n;
    rise = sck_n & ~s_q.sck_st;
    fall = ~sck_n & s_q.sck_st;
    s_d.wlk = lk[0];
    s_d.rlk = lk[1];

    if (cs_n & ~s_q.cs_st) begin
      // frame end: commit on exact length only
      case (s_q.st)
        D_DATA: begin
          if (s_q.op == `PM_OP_MAP_WRITE && s_q.ncnt == DATA_NIB + 5'h02
              && s_q.wel && !s_q.frozen) begin
            s_d.map = LARGE ? s_q.sh : {32'h0, s_q.sh[47:0]};
            s_d.wel = 1'b0;
          end else if (s_q.op == `PM_OP_MAP_FREEZE && s_q.ncnt == 5'h02
                       && s_q.wel) begin
            s_d.frozen = 1'b1;
            s_d.wel    = 1'b0;
          end else if (s_q.op == `PM_OP_LATCH_SET && s_q.ncnt == 5'h02) begin
            s_d.wel = 1'b1;
          end else if (s_q.op == `PM_OP_LATCH_CLR && s_q.ncnt == 5'h02) begin
            s_d.wel = 1'b0;
          end
        end
        default: begin
        end
      endcase
      s_d.st   = D_IDLE;
      s_d.doe  = 1'b0;
      s_d.dout = 4'h0;
      s_d.ncnt = 5'h00;
    end else if (~cs_n & s_q.cs_st) begin
      s_d.st   = D_CMD;
      s_d.ncnt = 5'h00;
      s_d.op   = 8'h00;
    end else if (~cs_n) begin
      case (s_q.st)
        D_CMD: begin
          if (rise) begin
            opc      = {s_q.op[3:0], io_n};
            s_d.op   = opc;
            s_d.ncnt = s_q.ncnt + 5'h01;
            if (s_q.ncnt == 5'h01) begin
              if (opc == `PM_OP_MAP_READ) begin
                s_d.st = D_READ;
                s_d.sh = s_q.map << (7'h50 - MAP_BITS);
              end else begin
                s_d.st = D_DATA;
              end
            end
          end
        end
        D_DATA: begin
          if (rise) begin
            s_d.sh = {s_q.sh[75:0], io_n};
            if (s_q.ncnt != 5'h1F) begin
              s_d.ncnt = s_q.ncnt + 5'h01;
            end
          end
        end
        D_READ: begin
          if (fall) begin
            s_d.doe  = 1'b1;
            s_d.dout = s_q.sh[79:76];
            s_d.sh   = {s_q.sh[75:0], 4'h0};
          end
        end
        D_SKIP: begin
        end
        default: begin
          s_d.st = D_IDLE;
        end
      endcase
    end
  end

  // ****************************************
  // state register
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q        <= '0;
      s_q.sck_s  <= 3'h0;
      s_q.cs_s   <= 3'h7;
      s_q.cs_st  <= 1'b1;
      s_q.io_s   <= 12'hFFF;
      s_q.io_st  <= 4'hF;
      s_q.st     <= D_IDLE;
      s_q.map    <= MAP_RST;
      s_q.frozen <= 1'b0;
      s_q.wlk    <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign link.dev_io  = s_q.dout;
  assign link.dev_oe  = s_q.doe;
  assign prog_blocked = s_q.wlk;
  assign read_blocked = s_q.rlk;
  assign map_out      = s_q.map;
  assign latch_out    = s_q.wel;
  assign frozen_out   = s_q.frozen;

endmodule

/* src/protect_map_host.sv */
/*
  Host end: AXI4-Lite register slave that runs one link command at a time,
  making the serial clock by dividing aclk.
  Assumes the device answers reads within half a serial clock period.
*/
`timescale 1ns/1ps
`include "protect_map_regs.svh"
module protect_map_host
  import protect_map_pkg::*;
#(
  parameter bit LARGE = 1'b0
) (
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // write channels
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output      logic        awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output      logic        wready,
  output      logic [1:0]  bresp,
  output      logic        bvalid,
  input  wire logic        bready,
  // read channels
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output      logic        arready,
  output      logic [31:0] rdata,
  output      logic [1:0]  rresp,
  output      logic        rvalid,
  input  wire logic        rready,
  // link
  protect_link_if.host     link
);

  localparam logic [4:0] DATA_NIB = LARGE ? `PM_NIB_32 : `PM_NIB_16;
  localparam logic [7:0] HALF     = 8'(`PM_SCK_HALF);

  typedef struct packed {
    logic [11:0] io_s;
    logic [3:0]  io_st;
    host_state_e st;
    host_op_e    op;
    logic [7:0]  div;
    logic [4:0]  nib;
    logic [4:0]  total;
    logic [87:0] tx;
    logic [79:0] txmap;
    logic [79:0] rx;
    logic        busy;
    logic        sck;
    logic        cs_n;
    logic [3:0]  hout;
    logic        hoe;
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [1:0]  rresp;
    logic [31:0] rdata;
  } host_s;

  host_s s_q;
  host_s s_d;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic [7:0] opcode_of(input host_op_e o);
    case (o)
      OP_LATCH:  return `PM_OP_LATCH_SET;
      OP_WRITE:  return `PM_OP_MAP_WRITE;
      OP_FREEZE: return `PM_OP_MAP_FREEZE;
      default:   return `PM_OP_MAP_READ;
    endcase
  endfunction

  always_comb begin
    logic [31:0] w;
    logic [3:0]  io_n;
    s_d  = s_q;
    w    = 32'h0;
    s_d.io_s  = {s_q.io_s[7:0], link.io};
    io_n      = (s_q.io_s[11:8] == s_q.io_s[7:4]) ? s_q.io_s[7:4] : s_q.io_st;
    s_d.io_st = io_n;

    // ****************************************
    // register bus
    // ****************************************
    s_d.awready = 1'b0;
    s_d.wready  = 1'b0;
    if (s_q.awready) begin
      s_d.bvalid = 1'b1;
      s_d.bresp  = `PM_RESP_OKAY;
      case (awaddr)
        `PM_OFS_CMD: begin
          if (!s_q.busy && wstrb[0]) begin
            s_d.op    = host_op_e'(wdata[1:0]);
            s_d.busy  = 1'b1;
            s_d.st    = H_LOW;
            s_d.div   = 8'h00;
            s_d.nib   = 5'h00;
            s_d.cs_n  = 1'b0;
            s_d.total = (wdata[1:0] == 2'h1 || wdata[1:0] == 2'h3) ?
                        DATA_NIB + 5'h02 : 5'h02;
            s_d.tx    = {opcode_of(host_op_e'(wdata[1:0])),
                         LARGE ? s_q.txmap : {s_q.txmap[47:0], 32'h0}};
            s_d.hout  = 4'(opcode_of(host_op_e'(wdata[1:0])) >> 4);
            s_d.hoe   = 1'b1;
          end
        end
        `PM_OFS_TX0: s_d.txmap[31:0]  = merge(s_q.txmap[31:0], wdata, wstrb);
        `PM_OFS_TX1: s_d.txmap[63:32] = merge(s_q.txmap[63:32], wdata, wstrb);
        `PM_OFS_TX2: begin
          w = merge({16'h0, s_q.txmap[79:64]}, wdata, wstrb);
          s_d.txmap[79:64] = w[15:0];
        end
        `PM_OFS_STATUS, `PM_OFS_RX0, `PM_OFS_RX1, `PM_OFS_RX2: begin
        end
        default: s_d.bresp = `PM_RESP_SLVERR;
      endcase
    end else if (awvalid && wvalid && !s_q.bvalid) begin
      s_d.awready = 1'b1;
      s_d.wready  = 1'b1;
    end
    if (s_q.bvalid && bready) begin
      s_d.bvalid = 1'b0;
    end

    s_d.arready = 1'b0;
    if (s_q.arready) begin
      s_d.rvalid = 1'b1;
      s_d.rresp  = `PM_RESP_OKAY;
      case (araddr)
        `PM_OFS_CMD:    s_d.rdata = {30'h0, s_q.op};
        `PM_OFS_STATUS: s_d.rdata = {31'h0, s_q.busy};
        `PM_OFS_TX0:    s_d.rdata = s_q.txmap[31:0];
        `PM_OFS_TX1:    s_d.rdata = s_q.txmap[63:32];
        `PM_OFS_TX2:    s_d.rdata = {16'h0, s_q.txmap[79:64]};
        `PM_OFS_RX0:    s_d.rdata = s_q.rx[31:0];
        `PM_OFS_RX1:    s_d.rdata = s_q.rx[63:32];
        `PM_OFS_RX2:    s_d.rdata = {16'h0, s_q.rx[79:64]};
        default: begin
          s_d.rdata = 32'h0;
          s_d.rresp = `PM_RESP_SLVERR;
        end
      endcase
    end else if (arvalid && !s_q.rvalid) begin
      s_d.arready = 1'b1;
    end
    if (s_q.rvalid && rready) begin
      s_d.rvalid = 1'b0;
    end

    // ****************************************
    // link sequencer
    // ****************************************
    case (s_q.st)
      H_IDLE: begin
      end
      H_LOW: begin
        s_d.div = s_q.div + 8'h01;
        if (s_q.div == HALF - 8'h01) begin
          s_d.div = 8'h00;
          s_d.sck = 1'b1;
          s_d.st  = H_HIGH;
          if (s_q.op == OP_READ && s_q.nib >= 5'h02) begin
            s_d.rx = {s_q.rx[75:0], io_n};
          end
        end
      end
      H_HIGH: begin
        s_d.div = s_q.div + 8'h01;
        if (s_q.div == HALF - 8'h01) begin
          s_d.div = 8'h00;
          s_d.sck = 1'b0;
          s_d.nib = s_q.nib + 5'h01;
          if (s_q.nib + 5'h01 == s_q.total) begin
            s_d.st  = H_END;
            s_d.hoe = 1'b0;
          end else begin
            s_d.tx   = {s_q.tx[83:0], 4'h0};
            s_d.hout = s_q.tx[83:80];
            s_d.hoe  = !(s_q.op == OP_READ && s_q.nib >= 5'h01);
            s_d.st   = H_LOW;
          end
        end
      end
      H_END: begin
        s_d.div = s_q.div + 8'h01;
        if (s_q.div == HALF - 8'h01) begin
          s_d.div  = 8'h00;
          s_d.cs_n = 1'b1;
          s_d.hoe  = 1'b0;
          s_d.st   = H_GAP;
        end
      end
      H_GAP: begin
        s_d.div = s_q.div + 8'h01;
        if (s_q.div == HALF - 8'h01) begin
          s_d.div  = 8'h00;
          s_d.busy = 1'b0;
          s_d.st   = H_IDLE;
        end
      end
      default: s_d.st = H_IDLE;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q       <= '0;
      s_q.io_s  <= 12'hFFF;
      s_q.io_st <= 4'hF;
      s_q.st    <= H_IDLE;
      s_q.op    <= OP_LATCH;
      s_q.cs_n  <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign awready      = s_q.awready;
  assign wready       = s_q.wready;
  assign bvalid       = s_q.bvalid;
  assign bresp        = s_q.bresp;
  assign arready      = s_q.arready;
  assign rvalid       = s_q.rvalid;
  assign rresp        = s_q.rresp;
  assign rdata        = s_q.rdata;
  assign link.sck     = s_q.sck;
  assign link.cs_n    = s_q.cs_n;
  assign link.host_io = s_q.hout;
  assign link.host_oe = s_q.hoe;

endmodule

/* tb/protect_link_monitor.sv */
/*
  Checker of the four-bit link between controller and device.
  Assumes the interface signals as plain inputs, one aclk domain.
*/
`timescale 1ns/1ps
`include "protect_map_regs.svh"
module protect_link_monitor #(
  parameter int NIB = 12
) (
  // clock and reset
  input wire logic       aclk,
  input wire logic       aresetn,
  // link
  input wire logic       sck,
  input wire logic       cs_n,
  input wire logic [3:0] host_io,
  input wire logic       host_oe,
  input wire logic [3:0] dev_io,
  input wire logic       dev_oe,
  input wire logic [3:0] io
);
  logic       sck_q;
  logic [4:0] ph_q;
  logic [4:0] rise_q;
  logic [3:0] hi_q;
  wire        rise = sck && !sck_q;

  // ****************************************
  // phase length and nibble count per frame
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sck_q  <= 1'h0;
      ph_q   <= 5'h00;
      rise_q <= 5'h00;
      hi_q   <= 4'h0;
    end else begin
      sck_q  <= sck;
      ph_q   <= cs_n ? 5'h00 : ((sck != sck_q) ? 5'h01 : ph_q + 5'h01);
      rise_q <= cs_n ? 5'h00 : (rise ? rise_q + 5'h01 : rise_q);
      if (rise && rise_q == 5'h00) begin
        hi_q <= io;
      end
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_reset_idle: assert property (
    $rose(aresetn) |-> cs_n && !sck && !host_oe && !dev_oe) else $error("link busy after reset");
  a_no_contention: assert property (!(host_oe && dev_oe))
    else $error("both ends drive the link");
  a_sck_idle: assert property (cs_n |-> !sck) else $error("clock runs outside frame");
  a_sck_half: assert property (
    (sck != sck_q) && !cs_n |-> ph_q == `PM_SCK_HALF) else $error("clock phase length wrong");
  a_nibble_hold: assert property (
    sck && sck_q && host_oe |-> $stable(host_io)) else $error("nibble changed while clock high");
  a_select_gap: assert property ($rose(cs_n) |-> cs_n [*8])
    else $error("select gap too short");
  a_frame_len: assert property (
    $rose(cs_n) |-> rise_q == 5'h02 || rise_q == NIB + 2) else $error("frame nibble count wrong");
  a_op_order: assert property (
    rise && rise_q == 5'h01 && host_oe |-> {hi_q, io} inside {8'h06, 8'h42, 8'h8D, 8'h72})
    else $error("opcode nibbles out of order");
  a_dev_release: assert property (
    cs_n && $past(cs_n, 8) |-> !dev_oe) else $error("device drives outside frame");
endmodule

/* tb/block_protect_map_write_lockdown_tb.sv */
/*
  Bench: AXI4-Lite orders to the controller, device map and lock outputs checked.
  Assumes a small controller and device; a large device listens on a copy of the link.
*/
`timescale 1ns/1ps
`include "protect_map_regs.svh"
module block_protect_map_write_lockdown_tb
  import protect_map_pkg::*;
;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, r;
  logic [21:0] chk_addr;
  logic        prog_blocked, read_blocked, latch_out, frozen_out;
  logic [79:0] map_out;
  logic        prog_l, read_l, latch_l, frozen_l;
  logic [79:0] map_l;
  logic [47:0] m, rb;
  int          error_cnt, check_count, cyc;
  logic [21:0] corner [15] = '{22'h000000, 22'h001FFF, 22'h002000, 22'h006000, 22'h007FFF,
    22'h008000, 22'h00FFFF, 22'h010000, 22'h1EFFFF, 22'h1F0000, 22'h1F7FFF, 22'h1F8000,
    22'h1FE000, 22'h1FFFFF, 22'h200000};

  protect_link_if link ();
  protect_map_host #(.LARGE(1'h0)) u_protect_map_host (.aclk(aclk), .aresetn(aresetn),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .link(link));
  protect_map_device #(.LARGE(1'h0)) u_protect_map_device (.aclk(aclk), .aresetn(aresetn),
    .link(link), .chk_addr(chk_addr), .prog_blocked(prog_blocked),
    .read_blocked(read_blocked), .map_out(map_out), .latch_out(latch_out),
    .frozen_out(frozen_out));
  protect_link_monitor #(.NIB(12)) u_protect_link_monitor (.aclk(aclk), .aresetn(aresetn),
    .sck(link.sck), .cs_n(link.cs_n), .host_io(link.host_io), .host_oe(link.host_oe),
    .dev_io(link.dev_io), .dev_oe(link.dev_oe), .io(link.io));
  // large device sees every frame, short map writes must be refused
  protect_link_if link_b ();
  assign link_b.sck     = link.sck;
  assign link_b.cs_n    = link.cs_n;
  assign link_b.host_io = link.host_io;
  assign link_b.host_oe = link.host_oe;
  protect_map_device #(.LARGE(1'h1)) u_protect_map_device_l (.aclk(aclk), .aresetn(aresetn),
    .link(link_b), .chk_addr(chk_addr), .prog_blocked(prog_l), .read_blocked(read_l),
    .map_out(map_l), .latch_out(latch_l), .frozen_out(frozen_l));

  // ****************************************
  // helpers
  // ****************************************
  task automatic check(input string what, input logic [79:0] seen, input logic [79:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] resp);
    logic done;
    done = 1'h0;
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= v;
    wstrb   <= 4'hF;
    awvalid <= 1'h1;
    wvalid  <= 1'h1;
    bready  <= 1'h1;
    while (!done) begin
      @(posedge aclk);
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
      if (bvalid) begin
        resp = bresp;
        bready <= 1'h0;
        done = 1'h1;
      end
    end
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] resp);
    logic done;
    done = 1'h0;
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'h1;
    rready  <= 1'h1;
    while (!done) begin
      @(posedge aclk);
      if (arready) arvalid <= 1'h0;
      if (rvalid) begin
        v = rdata;
        resp = rresp;
        rready <= 1'h0;
        done = 1'h1;
      end
    end
  endtask

  // order a command, then poll until the frame is over
  task automatic cmd(input logic [1:0] op);
    wr(`PM_OFS_CMD, {30'h0, op}, r);
    d = 32'h1;
    while (d[0] !== 1'h0) rd(`PM_OFS_STATUS, d, r);
    repeat (4) @(posedge aclk);
  endtask

  task automatic put_map(input logic [47:0] v);
    wr(`PM_OFS_TX0, v[31:0], r);
    wr(`PM_OFS_TX1, {16'h0, v[47:32]}, r);
    wr(`PM_OFS_TX2, 32'h0, r);
    cmd(OP_WRITE);
  endtask

  function automatic logic [1:0] exp_lock(input logic [47:0] v, input logic [21:0] a);
    int k;
    if (a > 22'h1FFFFF) return 2'h0;
    if (a >= 22'h1F8000) begin
      k = 40 + 2 * int'((a - 22'h1F8000) >> 13);
      return {v[k+1], v[k]};
    end
    if (a >= 22'h1F0000) return {1'h0, v[31]};
    if (a < 22'h008000) begin
      k = 32 + 2 * int'(a >> 13);
      return {v[k+1], v[k]};
    end
    if (a < 22'h010000) return {1'h0, v[30]};
    return {1'h0, v[int'(a >> 16) - 1]};
  endfunction

  task automatic sweep(input logic [47:0] v);
    logic [21:0] a;
    logic [1:0]  e;
    for (int i = 0; i < 19; i++) begin
      a = (i < 15) ? corner[i] : 22'($urandom);
      chk_addr <= a;
      repeat (2) @(posedge aclk);
      e = exp_lock(v, a);
      check("prog_blocked", prog_blocked, e[0]);
      check("read_blocked", read_blocked, e[1]);
      check("prog_blocked_l", prog_l, 1'h1);
      check("read_blocked_l", read_l, 1'h0);
    end
  endtask

  // ****************************************
  // clock, timeout and tests
  // ****************************************
  initial begin
    aclk = 1'h0;
    forever #50 aclk = ~aclk;
  end

  always @(posedge aclk) begin
    cyc++;
    if (cyc == 40000) begin
      error_cnt++;
      close_out();
    end
  end

  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
    {awaddr, araddr, wdata, wstrb, chk_addr} = '0;
    error_cnt = 0;
    check_count = 0;
    cyc = 0;
    void'($urandom(25));
    repeat (4) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    check("map", map_out, `PM_RST_16);
    check("latch", latch_out, 1'h0);
    check("frozen", frozen_out, 1'h0);
    check("map_l", map_l, `PM_RST_32);
    sweep(48'(`PM_RST_16));
    put_map(48'({$urandom, $urandom}));
    check("map", map_out, `PM_RST_16);
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      m = (i == 0) ? 48'h0 : (i == 1) ? 48'hFFFF_FFFF_FFFF : 48'({$urandom, $urandom});
      cmd(OP_LATCH);
      check("latch", latch_out, 1'h1);
      put_map(m);
      check("map", map_out, {32'h0, m});
      check("latch", latch_out, 1'h0);
      check("map_l", map_l, `PM_RST_32);
      check("latch_l", latch_l, 1'h1);
      rd(`PM_OFS_CMD, d, r);
      check("last_op", d[1:0], OP_WRITE);
      cmd(OP_READ);
      rd(`PM_OFS_RX0, d, r);
      rb[31:0] = d;
      rd(`PM_OFS_RX1, d, r);
      rb[47:32] = d[15:0];
      check("readback", rb, m);
      sweep(m);
    end
    $display("test write done");
    cmd(OP_FREEZE);
    check("frozen", frozen_out, 1'h0);
    check("frozen_l", frozen_l, 1'h1);
    cmd(OP_LATCH);
    cmd(OP_FREEZE);
    check("frozen", frozen_out, 1'h1);
    cmd(OP_LATCH);
    put_map(~m);
    check("map", map_out, {32'h0, m});
    $display("test freeze done");
    wr(8'h40, 32'h0, r);
    check("bresp", r, `PM_RESP_SLVERR);
    rd(8'h40, d, r);
    check("rresp", r, `PM_RESP_SLVERR);
    check("rdata", d, 32'h0);
    $display("test unmapped done");
    aresetn <= 1'h0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    check("frozen", frozen_out, 1'h0);
    check("frozen_l", frozen_l, 1'h0);
    check("map_l", map_l, `PM_RST_32);
    check("map", map_out, `PM_RST_16);
    m = 48'({$urandom, $urandom});
    cmd(OP_LATCH);
    put_map(m);
    check("map", map_out, {32'h0, m});
    $display("test power cycle done");
    close_out();
  end
endmodule
